// ### verilog/rxsb_top.sv
// receive buffer register bank for two channels, reached over apb
//
// Behaviour
// - enable register: B underflow..full, A likewise
// - reading empty data register flags underflow
// - loading unread data register flags overflow
// - end of frame after valid bit, gap exceeds length
// - length zero: first invalid bit ends frame
// - full byte or partial at eof loads register
// - status: valid-all, flow, eof, full per channel
// - reading status clears pending eof bits
// - data read-only, first bit in bit 0
// - valid bit marks each received data bit
// - valid-all only when all eight bits valid
// - status bits set regardless of enables
// - eof length in control bits 2:0
`include "rxsb_regs.svh"
module rxsb_top
    import rxsb_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bit_tick,
    input  wire logic [1:0]  rx_bit_valid,
    input  wire logic [1:0]  rx_bit_data,
    output logic             irq
);
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    // three stages; a change counts once stages two and three agree
    logic [4:0] s1_q, s2_q, s3_q, flt_q;
    wire  [4:0] raw = {bit_tick, rx_bit_valid, rx_bit_data};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q  <= 5'h00;
            s2_q  <= 5'h00;
            s3_q  <= 5'h00;
            flt_q <= 5'h00;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            flt_q <= (s2_q & s3_q) | (flt_q & (s2_q | s3_q));
        end
    end

    logic tick_prev_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tick_prev_q <= 1'b0;
        else          tick_prev_q <= flt_q[4];
    end
    // the bit strobe is taken on its rising edge so a long pulse counts once
    wire tick_rise = flt_q[4] && !tick_prev_q;

    // ****************************************************************
    // apb decode
    // ****************************************************************
    wire       acc      = psel && penable;
    wire       wr       = acc && pwrite;
    // read side effects act at the setup edge, where prdata is captured, so a load
    // or eof landing between capture and access is never lost
    wire       rd       = psel && !penable && !pwrite;
    wire [7:0] idx      = paddr[9:2];
    wire       aligned  = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    wire       hit_ctl  = aligned && idx == `RXSB_IDX_SERDES_CTL;
    wire       hit_en   = aligned && idx == `RXSB_IDX_EVENT_ENABLE;
    wire       hit_st   = aligned && idx == `RXSB_IDX_EVENT_STATUS;
    wire       hit_da   = aligned && idx == `RXSB_IDX_BYTE_A;
    wire       hit_va   = aligned && idx == `RXSB_IDX_VALID_A;
    wire       hit_db   = aligned && idx == `RXSB_IDX_BYTE_B;
    wire       hit_vb   = aligned && idx == `RXSB_IDX_VALID_B;
    wire       hit_rc   = aligned && idx == `RXSB_IDX_RX_CTRL;
    wire       mapped   = hit_ctl | hit_en | hit_st | hit_da | hit_va | hit_db | hit_vb | hit_rc;
    // read-only registers refuse writes with an error
    wire       ro_write = pwrite && (hit_st | hit_da | hit_va | hit_db | hit_vb);
    wire       wr_lane0 = wr && pstrb[0] && !ro_write;

    assign pready  = 1'b1;
    assign pslverr = acc && (!mapped || ro_write);

    // ****************************************************************
    // control registers
    // ****************************************************************
    logic [7:0] ctl_q, en_q, rxc_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= `RXSB_CTL_RESET;
            en_q  <= `RXSB_ENABLE_RESET;
            rxc_q <= `RXSB_RX_CTRL_RESET;
        end else begin
            if (wr_lane0 && hit_ctl) ctl_q <= {4'h0, pwdata[3:0]};
            if (wr_lane0 && hit_en)  en_q  <= pwdata[7:0];
            if (wr_lane0 && hit_rc)  rxc_q <= {6'h00, pwdata[1:0]};
        end
    end

    wire rxsb_eof_len_t eof_len = ctl_q[`RXSB_EOF_LEN_MSB:`RXSB_EOF_LEN_LSB];

    // ****************************************************************
    // channels
    // ****************************************************************
    rxsb_chan_if ch_if [2] ();
    logic [1:0] read_data;
    logic [1:0] load_v;
    logic [1:0] eof_v;
    rxsb_byte_t data_v  [2];
    rxsb_byte_t valid_v [2];
    logic [3:0] st_v    [2];
    logic [1:0] over_v, under_v;
    assign read_data = {rd && hit_db, rd && hit_da};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            rxsb_chan #(
                .WIDTH(8)
            ) u_chan (
                .pclk     (pclk),
                .presetn  (presetn),
                .enable   (rxc_q[g]),
                .bit_tick (tick_rise),
                .bit_val  (flt_q[2 + g]),
                .bit_dat  (flt_q[g]),
                .eof_len  (eof_len),
                .port     (ch_if[g].chan)
            );

            logic       unread_q, flow_q, eof_st_q;
            rxsb_byte_t data_q, valid_q;

            assign load_v[g] = ch_if[g].load;
            assign eof_v[g]  = ch_if[g].eof;
            // underflow: host reads with no unread data; a load in the same cycle does not count as data
            assign under_v[g] = read_data[g] && !unread_q;
            assign over_v[g]  = load_v[g] && unread_q && !read_data[g];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    unread_q <= 1'b0;
                    flow_q   <= 1'b0;
                    eof_st_q <= 1'b0;
                    data_q   <= 8'h00;
                    valid_q  <= 8'h00;
                end else begin
                    if (load_v[g]) begin
                        data_q   <= ch_if[g].data;
                        valid_q  <= ch_if[g].valid;
                        unread_q <= 1'b1;
                    end else if (read_data[g]) begin
                        unread_q <= 1'b0;
                    end
                    // flow violation is sticky until the host reads the data register
                    if (over_v[g] || under_v[g]) flow_q <= 1'b1;
                    else if (read_data[g])       flow_q <= 1'b0;
                    // a new eof wins over the clear by a status read
                    if (eof_v[g])                eof_st_q <= 1'b1;
                    else if (rd && hit_st)       eof_st_q <= 1'b0;
                end
            end

            assign data_v[g]  = data_q;
            assign valid_v[g] = valid_q;
            assign st_v[g] = {valid_q == 8'hff && unread_q, flow_q, eof_st_q, unread_q};
        end
    endgenerate

    // ****************************************************************
    // status, interrupt and read data
    // ****************************************************************
    wire [7:0] status = {st_v[1], st_v[0]};
    wire [1:0] full_v = {st_v[1][`RXSB_ST_FULL], st_v[0][`RXSB_ST_FULL]};
    wire [1:0] eofp_v = {st_v[1][`RXSB_ST_EOF], st_v[0][`RXSB_ST_EOF]};
    wire [1:0] flow_v = {st_v[1][`RXSB_ST_FLOW], st_v[0][`RXSB_ST_FLOW]};

    // flow shares one status bit, so both flow enables gate it
    wire [1:0] ch_irq;
    assign ch_irq[0] = (full_v[0] && en_q[`RXSB_EN_FULL])
                     || (eofp_v[0] && en_q[`RXSB_EN_EOF])
                     || (flow_v[0] && (en_q[`RXSB_EN_OVER] || en_q[`RXSB_EN_UNDER]));
    assign ch_irq[1] = (full_v[1] && en_q[4 + `RXSB_EN_FULL])
                     || (eofp_v[1] && en_q[4 + `RXSB_EN_EOF])
                     || (flow_v[1] && (en_q[4 + `RXSB_EN_OVER] || en_q[4 + `RXSB_EN_UNDER]));

    logic irq_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq_q <= 1'b0;
        else          irq_q <= |ch_irq;
    end
    assign irq = irq_q;

    wire [7:0] rd_mux = hit_ctl ? ctl_q      :
                        hit_en  ? en_q       :
                        hit_st  ? status     :
                        hit_da  ? data_v[0]  :
                        hit_va  ? valid_v[0] :
                        hit_db  ? data_v[1]  :
                        hit_vb  ? valid_v[1] :
                        hit_rc  ? rxc_q      : 8'h00;

    logic [31:0] prdata_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)                  prdata_q <= 32'h0000_0000;
        else if (psel && !penable && !pwrite) prdata_q <= {24'h00_0000, rd_mux};
    end
    assign prdata = prdata_q;
endmodule : rxsb_top

// ### verilog/rxsb_regs.svh
// register offsets, field positions and reset values of the receive buffer
`ifndef RXSB_REGS_SVH
`define RXSB_REGS_SVH

// ****************************************************************
// register indices; byte address is four times the index
// ****************************************************************
`define RXSB_IDX_SERDES_CTL    8'h06
`define RXSB_IDX_EVENT_ENABLE  8'h07
`define RXSB_IDX_EVENT_STATUS  8'h08
`define RXSB_IDX_BYTE_A        8'h09
`define RXSB_IDX_VALID_A       8'h0a
`define RXSB_IDX_BYTE_B        8'h0b
`define RXSB_IDX_VALID_B       8'h0c
`define RXSB_IDX_RX_CTRL       8'h20

// ****************************************************************
// fields and reset values
// ****************************************************************
`define RXSB_EOF_LEN_MSB       2
`define RXSB_EOF_LEN_LSB       0
`define RXSB_CTL_RESET         8'h03
`define RXSB_ENABLE_RESET      8'h00
`define RXSB_STATUS_RESET      8'h00
`define RXSB_RX_CTRL_RESET     8'h00
`define RXSB_ST_FULL           0
`define RXSB_ST_EOF            1
`define RXSB_ST_FLOW           2
`define RXSB_ST_VALID_ALL      3
`define RXSB_EN_FULL           0
`define RXSB_EN_EOF            1
`define RXSB_EN_OVER           2
`define RXSB_EN_UNDER          3

`endif

// ### verilog/rxsb_pkg.sv
// types shared by the receive buffer modules
package rxsb_pkg;
    typedef logic [7:0] rxsb_byte_t;
    typedef logic [2:0] rxsb_eof_len_t;
    typedef enum logic [2:0] {
        RXSB_IDLE  = 3'b001,
        RXSB_FRAME = 3'b010,
        RXSB_GAP   = 3'b100
    } rxsb_state_t;
endpackage : rxsb_pkg

// ### verilog/rxsb_chan_if.sv
// signals between one channel deserialiser and the register bank
interface rxsb_chan_if;
    import rxsb_pkg::*;
    logic       load;
    rxsb_byte_t data;
    rxsb_byte_t valid;
    logic       eof;
    modport chan (output load, output data, output valid, output eof);
    modport bank (input load, input data, input valid, input eof);
endinterface : rxsb_chan_if

// ### verilog/rxsb_chan.sv
// one receive channel: collects bits and detects end of frame
`include "rxsb_regs.svh"
module rxsb_chan
    import rxsb_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          enable,
    input  wire logic          bit_tick,
    input  wire logic          bit_val,
    input  wire logic          bit_dat,
    input  wire rxsb_eof_len_t eof_len,
    rxsb_chan_if.chan          port
);
    // the byte path is built for eight bit times only
    if (WIDTH != 8) begin : g_width_check
        $error("rxsb_chan: width must be 8");
    end

    // ****************************************************************
    // bit collection
    // ****************************************************************
    rxsb_state_t state_q, state_d;
    rxsb_byte_t  sh_d_q, sh_v_q;
    logic [2:0]  pos_q;
    logic [3:0]  gap_q;
    logic        load_q, eof_q;
    rxsb_byte_t  out_d_q, out_v_q;

    wire take_bit   = enable && bit_tick && bit_val;
    wire miss_bit   = enable && bit_tick && !bit_val && (state_q != RXSB_IDLE);
    // gap count exceeds length: with length 0 the first miss already ends the frame
    wire eof_hit    = miss_bit && ({1'b0, gap_q} + 5'd1 > {2'b00, eof_len});
    // a missed bit time still uses up its position, so the byte keeps its holes
    wire slot       = take_bit || (miss_bit && !eof_hit);
    wire byte_done  = slot && (pos_q == 3'd7);
    wire partial    = (sh_v_q != 8'h00);
    wire [7:0] bitm = 8'h01 << pos_q;
    wire [7:0] dbit = (take_bit && bit_dat) ? bitm : 8'h00;
    wire [7:0] vbit = take_bit ? bitm : 8'h00;

    always_comb begin
        state_d = state_q;
        case (state_q)
            RXSB_IDLE:  if (take_bit) state_d = RXSB_FRAME;
            RXSB_FRAME: if (eof_hit) state_d = RXSB_IDLE;
                        else if (miss_bit) state_d = RXSB_GAP;
            RXSB_GAP:   if (eof_hit) state_d = RXSB_IDLE;
                        else if (take_bit) state_d = RXSB_FRAME;
            default:    state_d = RXSB_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= RXSB_IDLE;
            sh_d_q  <= 8'h00;
            sh_v_q  <= 8'h00;
            pos_q   <= 3'd0;
            gap_q   <= 4'd0;
            load_q  <= 1'b0;
            eof_q   <= 1'b0;
            out_d_q <= 8'h00;
            out_v_q <= 8'h00;
        end else begin
            state_q <= state_d;
            load_q  <= byte_done || (eof_hit && partial);
            eof_q   <= eof_hit;
            if (byte_done) begin
                out_d_q <= sh_d_q | dbit;
                out_v_q <= sh_v_q | vbit;
            end else if (eof_hit && partial) begin
                out_d_q <= sh_d_q;
                out_v_q <= sh_v_q;
            end
            if (slot) begin
                // first bit lands in bit 0, later ones fill upward; a miss stays invalid
                sh_d_q <= byte_done ? 8'h00 : (sh_d_q | dbit);
                sh_v_q <= byte_done ? 8'h00 : (sh_v_q | vbit);
                pos_q  <= pos_q + 3'd1;
                gap_q  <= take_bit ? 4'd0 : (gap_q + 4'd1);
            end else if (eof_hit) begin
                sh_d_q <= 8'h00;
                sh_v_q <= 8'h00;
                pos_q  <= 3'd0;
                gap_q  <= 4'd0;
            end
        end
    end

    assign port.load  = load_q;
    assign port.eof   = eof_q;
    assign port.data  = out_d_q;
    assign port.valid = out_v_q;
endmodule : rxsb_chan

// ### tb/rxsb_top_sva.sv
// assertion checker for the receive buffer register bank
`include "rxsb_regs.svh"
module rxsb_top_sva (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic        bit_tick,
    input  wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ****************************************************************
    // decode and helper counters
    // ****************************************************************
    wire logic [7:0] idx    = paddr[9:2];
    wire logic       acc    = psel && penable && paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00;
    wire logic       rd_acc = acc && !pwrite;
    wire logic       ro     = idx >= `RXSB_IDX_EVENT_STATUS && idx <= `RXSB_IDX_VALID_B;
    wire logic       hit    = ro || idx == `RXSB_IDX_SERDES_CTL
                              || idx == `RXSB_IDX_EVENT_ENABLE || idx == `RXSB_IDX_RX_CTRL;
    wire logic       en_wr  = acc && pwrite && pstrb[0] && idx == `RXSB_IDX_EVENT_ENABLE;
    logic [7:0]      en_q;
    // saturating ages: a quiet tick pin means no load can land behind a read
    logic [3:0]      idle_q;
    logic [3:0]      st_q;
    logic [3:0]      ra_q;
    function automatic logic [3:0] inc(input logic [3:0] c);
        return c + {3'h0, c != 4'hf};
    endfunction : inc
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q   <= 8'h00;
            idle_q <= 4'h0;
            st_q   <= 4'hf;
            ra_q   <= 4'hf;
        end else begin
            en_q   <= en_wr ? pwdata[7:0] : en_q;
            idle_q <= bit_tick ? 4'h0 : inc(idle_q);
            st_q   <= (rd_acc && idx == `RXSB_IDX_EVENT_STATUS) ? 4'h0 : inc(st_q);
            ra_q   <= (rd_acc && idx == `RXSB_IDX_BYTE_A) ? 4'h0 : inc(ra_q);
        end
    end
    // ****************************************************************
    // assertions
    // ****************************************************************
    AST_PREADY: assert property (pready)
        else $error("pready low");
    AST_SETUP_OK: assert property (psel && !penable |-> !pslverr)
        else $error("error flag in setup cycle");
    AST_HI_ZERO: assert property (rd_acc |=> $stable(prdata[31:8]) && prdata[31:8] == '0)
        else $error("upper read data not zero");
    AST_DECODE: assert property (acc && (!pwrite || pstrb[0]) |-> pslverr == (!hit || pwrite && ro))
        else $error("error response wrong");
    AST_EN_READ: assert property (rd_acc && idx == `RXSB_IDX_EVENT_ENABLE |-> prdata[7:0] == en_q)
        else $error("enable readback wrong");
    AST_IRQ_GATE: assert property (irq |-> $past(en_q) != 8'h00 || en_q != 8'h00)
        else $error("irq with all enables clear");
    AST_UNDERFLOW: assert property (rd_acc && idx == `RXSB_IDX_BYTE_A && ra_q < 4'h5
        && idle_q == 4'hf && en_q[`RXSB_EN_UNDER] |-> ##[1:3] irq)
        else $error("underflow raised no irq");
    AST_EOF_CLR: assert property (rd_acc && idx == `RXSB_IDX_EVENT_STATUS && st_q < 4'h5
        && idle_q == 4'hf |-> prdata[5] == 1'b0 && prdata[1] == 1'b0)
        else $error("end of frame not cleared by status read");
    COV_IRQ: cover property (irq);
    COV_ERR: cover property (acc && pslverr);
    COV_STAT: cover property (rd_acc && idx == `RXSB_IDX_EVENT_STATUS && prdata[7:0] != 8'h00);
endmodule : rxsb_top_sva

bind rxsb_top rxsb_top_sva u_rxsb_top_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bit_tick(bit_tick), .irq(irq)
);

// ### tb/rxsb_radio.sv
// behavioural model of the two radio receiver channels driving the bit pins
module rxsb_radio (
    input  wire logic       pclk,
    output logic            tick,
    output logic [1:0]      val,
    output logic [1:0]      dat
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        tick = 1'b0;
        val  = 2'b00;
        dat  = 2'b00;
    end
    // one bit time; the tick stays low between calls, so it stands still outside frames
    // invalid lanes flip their data so a stale level is never taken for a bit
    task automatic bit_time(input logic [1:0] v, input logic [1:0] d);
        @(posedge pclk);
        val <= v;
        dat <= (d & v) | (~dat & ~v);
        repeat (2) @(posedge pclk);
        tick <= 1'b1;
        repeat (4) @(posedge pclk);
        tick <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : bit_time
endmodule : rxsb_radio

// ### tb/rxsb_top_test.sv
// self-checking testbench of the receive buffer register bank
`include "rxsb_regs.svh"
module rxsb_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CTL = `RXSB_IDX_SERDES_CTL;
    localparam logic [7:0] EN  = `RXSB_IDX_EVENT_ENABLE;
    localparam logic [7:0] ST  = `RXSB_IDX_EVENT_STATUS;
    localparam logic [7:0] DA  = `RXSB_IDX_BYTE_A;
    localparam logic [7:0] VA  = `RXSB_IDX_VALID_A;
    localparam logic [7:0] DB  = `RXSB_IDX_BYTE_B;
    localparam logic [7:0] VB  = `RXSB_IDX_VALID_B;
    localparam logic [7:0] RXC = `RXSB_IDX_RX_CTRL;
    localparam logic [7:0] IDX [8] = '{CTL, EN, ST, DA, VA, DB, VB, RXC};
    localparam logic [7:0] RST [8] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [1:0]  rx_bit_valid;
    logic [1:0]  rx_bit_data;
    logic        pready, pslverr, irq, bit_tick, err;
    logic [7:0]  ba, bb;
    logic [2:0]  len;
    int          n_fail = 0;
    int          check_count = 0;
    int          seed = 18;
    rxsb_top u_rxsb_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bit_tick(bit_tick), .rx_bit_valid(rx_bit_valid),
        .rx_bit_data(rx_bit_data), .irq(irq)
    );
    rxsb_radio u_rxsb_radio (.pclk(pclk), .tick(bit_tick), .val(rx_bit_valid), .dat(rx_bit_data));
    initial begin
        forever #5 pclk = ~pclk;
    end
    // ****************************************************************
    // bus, compare and expectation helpers
    // ****************************************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {2'b00, a, 2'b00};
        pwdata <= {24'h00_0000, d};
        pstrb  <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00, 4'h0);
        chk(rd[7:0], exp);
    endtask : rdc
    // status nibble: valid-all needs the byte both complete and still unread
    function automatic logic [3:0] nib(input logic fu, input logic a8, input logic fl,
                                       input logic eo);
        return {fu && a8, fl, eo, fu};
    endfunction : nib
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    initial begin
        #50_000;
        n_fail++;
        final_report();
    end
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        do_reset();
        foreach (IDX[i]) rdc(IDX[i], RST[i]);
        ba = 8'($random(seed));
        apb(1'b1, EN, ba, 4'h1);
        rdc(EN, ba);
        apb(1'b1, EN, ~ba, 4'h0);
        rdc(EN, ba);
        apb(1'b1, DA, 8'h5a, 4'h1);
        chk({7'h00, err}, 8'h01);
        apb(1'b0, 8'h01, 8'h00, 4'h0);
        chk({7'h00, err}, 8'h01);
        rdc(DA, 8'h00);
        $display("test registers done");
        do_reset();
        apb(1'b1, RXC, 8'h03, 4'h1);
        apb(1'b1, CTL, 8'h00, 4'h1);
        ba = 8'($random(seed));
        bb = 8'($random(seed));
        for (int i = 0; i < 8; i++) begin
            u_rxsb_radio.bit_time(2'b11, {bb[i], ba[i]});
        end
        repeat (12) @(posedge pclk);
        rdc(ST, {nib(1'b1, 1'b1, 1'b0, 1'b0), nib(1'b1, 1'b1, 1'b0, 1'b0)});
        chk({7'h00, irq}, 8'h00);
        rdc(VA, 8'hff);
        apb(1'b1, EN, 8'h08, 4'h1);
        rdc(DA, ba);
        apb(1'b0, DA, 8'h00, 4'h0);
        repeat (2) @(posedge pclk);
        chk({7'h00, irq}, 8'h01);
        rdc(DB, bb);
        u_rxsb_radio.bit_time(2'b00, 2'b00);
        repeat (12) @(posedge pclk);
        rdc(ST, {nib(1'b0, 1'b1, 1'b0, 1'b1), nib(1'b0, 1'b1, 1'b1, 1'b1)});
        rdc(ST, {nib(1'b0, 1'b1, 1'b0, 1'b0), nib(1'b0, 1'b1, 1'b1, 1'b0)});
        $display("test full bytes done");
        do_reset();
        apb(1'b1, RXC, 8'h03, 4'h1);
        len = 3'(($random(seed) & 3) + 1);
        apb(1'b1, CTL, {5'h00, len}, 4'h1);
        bb = 8'($random(seed));
        u_rxsb_radio.bit_time(2'b10, {bb[0], 1'b0});
        u_rxsb_radio.bit_time(2'b00, 2'b00);
        u_rxsb_radio.bit_time(2'b10, {bb[2], 1'b0});
        repeat (len) u_rxsb_radio.bit_time(2'b00, 2'b00);
        repeat (12) @(posedge pclk);
        rdc(ST, 8'h00);
        u_rxsb_radio.bit_time(2'b00, 2'b00);
        repeat (12) @(posedge pclk);
        rdc(ST, {nib(1'b1, 1'b0, 1'b0, 1'b1), 4'h0});
        rdc(VB, 8'h05);
        apb(1'b1, EN, 8'h40, 4'h1);
        ba = 8'($random(seed));
        for (int i = 0; i < 8; i++) begin
            u_rxsb_radio.bit_time(2'b10, {ba[i], 1'b0});
        end
        repeat (12) @(posedge pclk);
        rdc(ST, {nib(1'b1, 1'b1, 1'b1, 1'b0), 4'h0});
        chk({7'h00, irq}, 8'h01);
        rdc(DB, ba);
        rdc(ST, 8'h00);
        chk({7'h00, irq}, 8'h00);
        $display("test partial frame and overflow done");
        final_report();
    end
endmodule : rxsb_top_test
